// File: bench/sas_monitor.sv
/*
 * Pin checker of the serial adapter, bound to sas_top.
 * Assumes one clock and a synchronous active low reset.
 */
module sas_monitor (
	input wire logic       clk_i,
	input wire logic       rst_b_i,
	input wire logic       chip_sel_0_i,
	input wire logic       chip_sel_1_i,
	input wire logic       chip_sel_2_n_i,
	input wire logic       reg_select_i,
	input wire logic       rw_i,
	input wire logic       enable_i,
	input wire logic [7:0] data_o,
	input wire logic       data_oe_n_o,
	input wire logic       irq_n_o,
	input wire logic       txd_o,
	input wire logic       cts_n_i,
	input wire logic       dcd_n_i
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************************
	// Relations between the pins
	// ****************************************************
	logic sel_rd;
	logic st_vis;
	// Selected read cycle and visible status byte
	assign sel_rd = chip_sel_0_i && chip_sel_1_i && !chip_sel_2_n_i && rw_i;
	assign st_vis = !data_oe_n_o && !reg_select_i;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence s_cts_still;
		$stable(cts_n_i) [*6];
	endsequence
	sequence s_dcd_lost;
		dcd_n_i [*6];
	endsequence
	property p_rst;
		disable iff (1'b0) !rst_b_i |=> txd_o && irq_n_o && data_oe_n_o;
	endproperty
	property p_drv_sel;
		$fell(data_oe_n_o) |-> $past(sel_rd && enable_i, 2);
	endproperty
	property p_drv_nosel;
		(!chip_sel_0_i) [*5] |-> data_oe_n_o;
	endproperty
	property p_irq_bit;
		st_vis && $stable(irq_n_o) |-> data_o[7] == !irq_n_o;
	endproperty
	property p_cts_bit;
		s_cts_still ##0 st_vis |-> data_o[3] == cts_n_i;
	endproperty
	property p_tx_empty_flag_cts;
		s_cts_still ##0 (st_vis && cts_n_i) |-> !data_o[1];
	endproperty
	property p_dcd_bits;
		s_dcd_lost ##0 st_vis |-> !data_o[0] && data_o[2];
	endproperty
	property p_bit_min;
		$changed(txd_o) |=> $stable(txd_o) [*7];
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset levels wrong");
	a_drv_sel: assert property (p_drv_sel)
		else $error("bus driven without selected read");
	a_drv_nosel: assert property (p_drv_nosel)
		else $error("bus driven while unselected");
	a_irq_bit: assert property (p_irq_bit)
		else $error("status bit 7 differs from interrupt pin");
	a_cts_bit: assert property (p_cts_bit)
		else $error("status bit 3 differs from clear to send");
	a_tx_empty_flag_cts: assert property (p_tx_empty_flag_cts)
		else $error("transmit empty not inhibited");
	a_dcd_bits: assert property (p_dcd_bits)
		else $error("carrier loss bits wrong");
	a_bit_min: assert property (p_bit_min)
		else $error("serial bit too short");
endmodule

bind sas_top sas_monitor mon_u (
	.clk_i(clk_i), .rst_b_i(rst_b_i), .chip_sel_0_i(chip_sel_0_i),
	.chip_sel_1_i(chip_sel_1_i), .chip_sel_2_n_i(chip_sel_2_n_i),
	.reg_select_i(reg_select_i), .rw_i(rw_i), .enable_i(enable_i),
	.data_o(data_o), .data_oe_n_o(data_oe_n_o), .irq_n_o(irq_n_o),
	.txd_o(txd_o), .cts_n_i(cts_n_i), .dcd_n_i(dcd_n_i)
);

// File: bench/sas_term_model.sv
/*
 * Far end of the serial line: a terminal sending and taking frames.
 * Assumes clk_i at 100 MHz and bit lengths given in its cycles.
 */
module sas_term_model (
	input  wire logic clk_i,
	input  wire logic txd_i,
	output logic      rxd_o
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****************************************************
	// Line driver and sampler
	// ****************************************************
	// Line rests at mark level
	initial rxd_o = 1'b1;
	// Start, data LSB first, parity, stops; errors on request
	task automatic send_char(input logic [7:0] d, input int nb,
		input logic hp, input logic odd, input int ns, input int bc,
		input logic bad_p, input logic bad_s);
		logic q[$];
		q.push_back(1'b0);
		for (int i = 0; i < nb; i++) begin
			q.push_back(d[i]);
		end
		if (hp) begin
			q.push_back((^(d & (nb == 7 ? 8'h7F : 8'hFF))) ^ odd ^ bad_p);
		end
		q.push_back(!bad_s);
		if (ns == 2) begin
			q.push_back(1'b1);
		end
		foreach (q[i]) begin
			rxd_o = q[i];
			repeat (bc) @(negedge clk_i);
		end
		rxd_o = 1'b1;
	endtask
	// Samples each sent bit at its centre
	task automatic recv_char(input int nb, input logic hp, input int ns,
		input int bc, output logic [7:0] d, output logic p,
		output logic ok);
		d = 8'h00;
		p = 1'b0;
		@(negedge txd_i);
		repeat (bc / 2) @(posedge clk_i);
		ok = !txd_i;
		for (int i = 0; i < nb + ns + hp; i++) begin
			repeat (bc) @(posedge clk_i);
			if (i < nb) d[i] = txd_i;
			else if (hp && i == nb) p = txd_i;
			else ok = ok & txd_i;
		end
	endtask
endmodule

// File: bench/sas_top_tb.sv
/*
 * Self-checking bench of the serial adapter: bus cycles, frames,
 * flags and modem lines. Assumes sas_top, the terminal model and
 * the pin checker are compiled first.
 */
module sas_top_tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_i, rst_b_i = 1'b0, c0 = 1'b0, c1 = 1'b1, c2n = 1'b1;
	logic rs = 1'b0, rw = 1'b1, en = 1'b0, cts_n = 1'b0, dcd_n = 1'b0;
	logic baud, rxd, txd, rts_n, oe_n, irq_n, gp, gs, hp, bp, bs;
	logic [7:0]  wd = 8'h00, rd, gd, m;
	logic [31:0] seed = 32'hD5E5;
	int          nb, ns, mismatches = 0, tests_run = 0;
	// ****************************************************
	// Design, far end, clocks
	// ****************************************************
	sas_top dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .chip_sel_0_i(c0),
		.chip_sel_1_i(c1), .chip_sel_2_n_i(c2n), .reg_select_i(rs),
		.rw_i(rw), .enable_i(en), .data_i(wd), .data_o(rd),
		.data_oe_n_o(oe_n), .irq_n_o(irq_n), .baud_switch_clk_i(baud),
		.rxd_i(rxd), .txd_o(txd), .rts_n_o(rts_n), .cts_n_i(cts_n),
		.dcd_n_i(dcd_n));
	sas_term_model term_u (.clk_i(clk_i), .txd_i(txd), .rxd_o(rxd));
	// System clock, 10 ns
	initial begin
		clk_i = 1'b0;
		forever #5 clk_i = ~clk_i;
	end
	// Baud clock, 200 ns, phase unrelated
	initial begin
		baud = 1'b0;
		#3;
		forever #100 baud = ~baud;
	end
	// ****************************************************
	// Helpers
	// ****************************************************
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] x;
		x = s ^ (s << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic ep(input logic [7:0] d, input logic odd);
		return (^d) ^ odd;
	endfunction
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	// One access held over a whole enable pulse
	task automatic bus(input logic [1:0] bad, input logic a,
		input logic r, input logic [7:0] w, output logic [7:0] q);
		@(negedge clk_i);
		c0 = (bad != 2'h1);
		c1 = (bad != 2'h2);
		c2n = (bad == 2'h3);
		rs = a;
		rw = r;
		wd = w;
		en = 1'b1;
		repeat (6) @(negedge clk_i);
		q = rd;
		en = 1'b0;
		repeat (5) @(negedge clk_i);
		c0 = 1'b0;
		rw = 1'b1;
	endtask
	task automatic wr(input logic a, input logic [7:0] w);
		logic [7:0] q;
		bus(2'h0, a, 1'b0, w, q);
	endtask
	task automatic rdc(input logic a, input logic [7:0] e);
		logic [7:0] q;
		bus(2'h0, a, 1'b1, 8'h00, q);
		chk(q, e);
	endtask
	task automatic close_out();
		if (mismatches == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	// Watchdog
	initial begin
		#980000;
		mismatches++;
		close_out();
	end
	// ****************************************************
	// Scenarios
	// ****************************************************
	initial begin
		repeat (4) @(negedge clk_i);
		rst_b_i = 1'b1;
		chk({5'h0, txd, irq_n, rts_n}, 8'h06);
		wr(1'b0, 8'h03);
		wr(1'b0, 8'hB1);
		rdc(1'b0, 8'h82);
		for (int f = 0; f < 8; f++) begin
			nb = (f > 3) ? 8 : 7;
			ns = (f < 2 || f == 4) ? 2 : 1;
			hp = (f != 4 && f != 5);
			bp = hp && !f[0];
			bs = (f == 3);
			m = (nb == 7) ? 8'h7F : 8'hFF;
			seed = xs(seed);
			wr(1'b0, 8'h03);
			wr(1'b0, {3'h0, f[2:0], 2'h1});
			fork
				term_u.recv_char(nb, hp, ns, 320, gd, gp, gs);
				wr(1'b1, seed[7:0]);
			join
			chk(gd, seed[7:0] & m);
			chk({7'h0, gp}, {7'h0, hp & ep(seed[7:0] & m, f[0])});
			chk({7'h0, gs}, 8'h01);
			term_u.send_char(seed[15:8], nb, hp, f[0], ns, 320, bp, bs);
			rdc(1'b0, {1'b0, bp, 1'b0, bs, 4'h3});
			rdc(1'b1, seed[15:8] & m);
			rdc(1'b0, {1'b0, bp, 1'b0, bs, 4'h2});
		end
		wr(1'b0, 8'h12);
		fork
			term_u.recv_char(8, 1'b0, 2, 1280, gd, gp, gs);
			wr(1'b1, seed[23:16]);
		join
		chk(gd, seed[23:16]);
		wr(1'b0, 8'h11);
		term_u.send_char(seed[7:0], 8, 1'b0, 1'b0, 2, 320, 1'b0, 1'b0);
		term_u.send_char(seed[15:8], 8, 1'b0, 1'b0, 2, 320, 1'b0, 1'b0);
		rdc(1'b0, 8'h03);
		rdc(1'b1, seed[7:0]);
		rdc(1'b0, 8'h23);
		bus(2'h0, 1'b1, 1'b1, 8'h00, gd);
		rdc(1'b0, 8'h02);
		wr(1'b0, 8'h91);
		term_u.send_char(8'h5A, 8, 1'b0, 1'b0, 2, 320, 1'b0, 1'b0);
		repeat (4) @(negedge clk_i);
		rdc(1'b0, 8'h83);
		rdc(1'b1, 8'h5A);
		chk({7'h0, irq_n}, 8'h01);
		dcd_n = 1'b1;
		repeat (8) @(negedge clk_i);
		chk({7'h0, irq_n}, 8'h00);
		rdc(1'b0, 8'h86);
		dcd_n = 1'b0;
		repeat (8) @(negedge clk_i);
		rdc(1'b0, 8'h86);
		bus(2'h0, 1'b1, 1'b1, 8'h00, gd);
		rdc(1'b0, 8'h02);
		cts_n = 1'b1;
		repeat (8) @(negedge clk_i);
		rdc(1'b0, 8'h08);
		wr(1'b0, 8'h03);
		rdc(1'b0, 8'h08);
		cts_n = 1'b0;
		wr(1'b0, 8'h51);
		chk({7'h0, rts_n}, 8'h01);
		wr(1'b0, 8'h71);
		chk({6'h0, rts_n, txd}, 8'h02);
		wr(1'b0, 8'h31);
		chk({5'h0, rts_n, txd, irq_n}, 8'h02);
		for (int b = 1; b < 4; b++) begin
			bus(b[1:0], 1'b0, 1'b0, 8'h03, gd);
		end
		chk({7'h0, irq_n}, 8'h00);
		wr(1'b0, 8'h03);
		chk({7'h0, irq_n}, 8'h01);
		rdc(1'b0, 8'h02);
		close_out();
	end
endmodule

// File: verilog/sas_defs.svh
/*
 * Register select codes, field positions, reset values and divide
 * periods of the serial adapter.
 * Assumes inclusion by bare name from package and modules.
 */
`ifndef SAS_DEFS_SVH
`define SAS_DEFS_SVH

// ****************************************************
// Register select codes
// ****************************************************
`define SAS_RS_CTRL    1'b0
`define SAS_RS_DATA    1'b1

// ****************************************************
// Control fields
// ****************************************************
`define SAS_DIV_MSB    1
`define SAS_DIV_LSB    0
`define SAS_FMT_MSB    4
`define SAS_FMT_LSB    2
`define SAS_TXC_MSB    6
`define SAS_TXC_LSB    5
`define SAS_RIE_BIT    7
`define SAS_RTS_BIT    6
`define SAS_DIV_1      2'h0
`define SAS_DIV_16     2'h1
`define SAS_DIV_64     2'h2
`define SAS_DIV_MRESET 2'h3
`define SAS_TXC_INT    2'h1
`define SAS_TXC_BRK    2'h3
`define SAS_CTRL_RST   8'h03

// ****************************************************
// Status bit positions
// ****************************************************
`define SAS_ST_FULL    0
`define SAS_ST_TEMPTY  1
`define SAS_ST_DCD     2
`define SAS_ST_CTS     3
`define SAS_ST_FE      4
`define SAS_ST_OVR     5
`define SAS_ST_PE      6
`define SAS_ST_IRQ     7

// ****************************************************
// Baud clock edges per bit
// ****************************************************
`define SAS_PER_1      7'h01
`define SAS_PER_16     7'h10
`define SAS_PER_64     7'h40

`endif

// File: verilog/sas_pkg.sv
/*
 * Types and shared functions of the serial adapter.
 * Assumes sas_defs.svh is on the include path.
 */
`include "sas_defs.svh"

package sas_pkg;

	// Pin bundle passed through the input synchroniser
	typedef struct packed {
		logic       cs0;
		logic       cs1;
		logic       cs2_n;
		logic       rs;
		logic       rw;
		logic       en;
		logic [7:0] d;
		logic       rxd;
		logic       cts_n;
		logic       dcd_n;
		logic       baud;
	} sas_pins_t;

	// Decoded character format
	typedef struct packed {
		logic eight;
		logic two_stop;
		logic par_en;
		logic odd;
	} sas_fmt_t;

	typedef enum logic [2:0] {
		SER_IDLE  = 3'h0,
		SER_START = 3'h1,
		SER_DATA  = 3'h3,
		SER_PAR   = 3'h2,
		SER_STOP  = 3'h6
	} sas_ser_st_t;

	// Format code to word length, stop bits and parity
	function automatic sas_fmt_t sas_fmt_decode(input logic [2:0] f);
		sas_fmt_t r;
		r.eight    = f[2];
		r.two_stop = (f[2:1] == 2'h0) || (f == 3'h4);
		r.par_en   = (f[2:1] != 2'h2);
		r.odd      = f[0];
		return r;
	endfunction

	// Divide select to baud clock edges per bit
	function automatic logic [6:0] sas_period(input logic [1:0] div);
		logic [6:0] p;
		p = `SAS_PER_1;
		if (div == `SAS_DIV_16) begin
			p = `SAS_PER_16;
		end else if (div == `SAS_DIV_64) begin
			p = `SAS_PER_64;
		end
		return p;
	endfunction

endpackage

// File: verilog/sas_rx.sv
/*
 * Receive shifter sampling each bit near its centre.
 * Assumes edge_p marks each baud clock rising edge, rxd synchronised.
 */
module sas_rx
	import sas_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	sas_ser_if.rx_mp  ser
);

	typedef struct packed {
		sas_ser_st_t st;
		logic [6:0]  cnt;
		logic [2:0]  idx;
		logic [7:0]  data;
		logic        par;
		logic        done;
		logic        fe;
		logic        pe;
	} rx_state_t;

	localparam rx_state_t RX_RST = '{st: SER_IDLE, default: '0};

	rx_state_t  r_reg;
	rx_state_t  r_next;
	sas_fmt_t   fmt;
	logic [6:0] per;
	logic [6:0] half;

	assign fmt         = sas_fmt_decode(ser.fmt);
	assign per         = sas_period(ser.div);
	assign half        = per >> 1;
	assign ser.rx_done = r_reg.done;
	assign ser.rx_data = r_reg.data;
	assign ser.rx_fe   = r_reg.fe;
	assign ser.rx_pe   = r_reg.pe;

	// Start hunt, then one centre sample per bit period
	always_comb begin
		r_next      = r_reg;
		r_next.done = 1'b0;
		if (ser.edge_p) begin
			if (r_reg.st == SER_IDLE) begin
				if (!ser.rxd) begin
					r_next.st  = SER_START;
					r_next.cnt = (half == 7'h0) ? 7'h0 : half - 7'h1;
				end
			end else if (r_reg.cnt != 7'h0) begin
				r_next.cnt = r_reg.cnt - 7'h1;
			end else begin
				r_next.cnt = per - 7'h1;
				case (r_reg.st)
					SER_START: begin
						r_next.st   = ser.rxd ? SER_IDLE : SER_DATA;
						r_next.idx  = 3'h0;
						r_next.data = 8'h00;
						r_next.par  = fmt.odd;
						r_next.pe   = 1'b0;
					end
					SER_DATA: begin
						r_next.data[r_reg.idx] = ser.rxd;
						r_next.par = r_reg.par ^ ser.rxd;
						if (r_reg.idx == (fmt.eight ? 3'h7 : 3'h6)) begin
							r_next.st = fmt.par_en ? SER_PAR : SER_STOP;
						end else begin
							r_next.idx = r_reg.idx + 3'h1;
						end
					end
					SER_PAR: begin
						r_next.pe = r_reg.par ^ ser.rxd;
						r_next.st = SER_STOP;
					end
					SER_STOP: begin
						r_next.fe   = !ser.rxd;
						r_next.done = 1'b1;
						r_next.st   = SER_IDLE;
					end
					default: begin
						r_next.st = SER_IDLE;
					end
				endcase
			end
		end
		if (!rst_b_i || ser.mr) begin
			r_next = RX_RST;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		r_reg <= r_next;
	end

endmodule

// File: verilog/sas_ser_if.sv
/*
 * Carrier between the adapter core and its serial engines.
 * Assumes all signals are driven on clk_i of the top module.
 */
interface sas_ser_if;
	logic       edge_p;
	logic       tick_p;
	logic [1:0] div;
	logic [2:0] fmt;
	logic       mr;
	logic       go;
	logic [7:0] tdr;
	logic       tx_busy;
	logic       tx_txd;
	logic       rxd;
	logic       rx_done;
	logic [7:0] rx_data;
	logic       rx_fe;
	logic       rx_pe;

	modport ctl_mp (output edge_p, tick_p, div, fmt, mr, go, tdr, rxd,
		input tx_busy, tx_txd, rx_done, rx_data, rx_fe, rx_pe);
	modport tx_mp (input tick_p, fmt, mr, go, tdr,
		output tx_busy, tx_txd);
	modport rx_mp (input edge_p, div, fmt, mr, rxd,
		output rx_done, rx_data, rx_fe, rx_pe);
endinterface

// File: verilog/sas_top.sv
/*
 * Asynchronous serial adapter: bus selection, control and status
 * registers, receive data register, divider and modem lines.
 * Assumes bus and modem pins are asynchronous to clk_i and that
 * the enable strobe lasts several clk_i periods.
 */
`include "sas_defs.svh"

// Overview of operation
// - Respond only with both high selects and the low select asserted.
// - Transfers happen during enable high; read/write sets direction.
// - Control bits 1:0 divide by 1, 16, 64; code 11 master resets.
// - Control bits 4:2 choose data bits, stop bits and parity.
// - Control bits 6:5 set request line, transmit interrupt and break.
// - Control bit 7 enables receive interrupts.
// - Select low with read returns the status byte.
// - Receive-full sets on data transfer; clears on data read, reset.
// - Carrier absent forces receive-full to read empty.
// - Transmit-empty low after data write until the idle transmitter takes it.
// - Carrier-loss latches; cleared by status then data read.
// - Carrier-loss raises interrupt when receive interrupts enabled.
// - Bit 3 mirrors clear-to-send; high inhibits transmit-empty.
// - Framing error set when first stop bit missing.
// - Overrun begins at last bit of second unread character.
// - Overrun shows after prior character read; clears on data read.
// - Parity error when ones count disagrees with odd/even choice.
// - No-parity formats suppress parity generation and checking.
// - Status bit 7 high exactly while interrupt output is low.
// - Divide-by-16 uses a baud clock sixteen times the bit rate.
// - Divide-by-64 runs at quarter rate; divide-by-1 takes one baud edge per bit.
module sas_top
	import sas_pkg::*;
(
	input  wire logic       clk_i,
	input  wire logic       rst_b_i,
	input  wire logic       chip_sel_0_i,
	input  wire logic       chip_sel_1_i,
	input  wire logic       chip_sel_2_n_i,
	input  wire logic       reg_select_i,
	input  wire logic       rw_i,
	input  wire logic       enable_i,
	input  wire logic [7:0] data_i,
	output logic [7:0]      data_o,
	output logic            data_oe_n_o,
	output logic            irq_n_o,
	input  wire logic       baud_switch_clk_i,
	input  wire logic       rxd_i,
	output logic            txd_o,
	output logic            rts_n_o,
	input  wire logic       cts_n_i,
	input  wire logic       dcd_n_i
);

	typedef struct packed {
		sas_pins_t  s1;
		sas_pins_t  s2;
		logic       en_q;
		logic       baud_q;
		logic       dcd_q;
		logic [6:0] div_cnt;
		logic       edge_p;
		logic       tick_p;
		logic       acc_sel;
		logic       acc_rs;
		logic       acc_rw;
		logic [7:0] acc_d;
		logic [7:0] ctrl;
		logic [7:0] tdr;
		logic       tx_empty_flag;
		logic       go;
		logic [7:0] rx_data_reg;
		logic       full;
		logic       fe;
		logic       pe;
		logic       ovr_pend;
		logic       ovr;
		logic       dcd_flag;
		logic       stat_rd;
		logic [7:0] dout;
		logic       oe_n;
		logic       irq_n;
		logic       txd;
	} top_state_t;

	// Power-up leaves the adapter in master reset
	localparam top_state_t TOP_RST = '{ctrl: `SAS_CTRL_RST,
		tx_empty_flag: 1'b1, oe_n: 1'b1, irq_n: 1'b1, txd: 1'b1, default: '0};

	top_state_t r_reg;
	top_state_t r_next;
	sas_pins_t  pins;
	sas_ser_if  ser ();

	// ****************************************************
	// Pin bundle and engine hookup
	// ****************************************************

	// Gather asynchronous pins for the synchroniser
	always_comb begin
		pins.cs0   = chip_sel_0_i;
		pins.cs1   = chip_sel_1_i;
		pins.cs2_n = chip_sel_2_n_i;
		pins.rs    = reg_select_i;
		pins.rw    = rw_i;
		pins.en    = enable_i;
		pins.d     = data_i;
		pins.rxd   = rxd_i;
		pins.cts_n = cts_n_i;
		pins.dcd_n = dcd_n_i;
		pins.baud  = baud_switch_clk_i;
	end

	// Engine controls straight from registers
	assign ser.edge_p = r_reg.edge_p;
	assign ser.tick_p = r_reg.tick_p;
	assign ser.div    = r_reg.ctrl[`SAS_DIV_MSB:`SAS_DIV_LSB];
	assign ser.fmt    = r_reg.ctrl[`SAS_FMT_MSB:`SAS_FMT_LSB];
	assign ser.mr     = (ser.div == `SAS_DIV_MRESET);
	assign ser.go     = r_reg.go;
	assign ser.tdr    = r_reg.tdr;
	assign ser.rxd    = r_reg.s2.rxd;

	sas_tx u_tx (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.ser     (ser)
	);

	sas_rx u_rx (
		.clk_i   (clk_i),
		.rst_b_i (rst_b_i),
		.ser     (ser)
	);

	// ****************************************************
	// Next-state logic
	// ****************************************************

	// Bus, flags, divider and interrupt update
	always_comb begin
		logic       sel_now;
		logic       en_fall;
		logic [6:0] per;
		logic       cts_hi;
		logic       full_vis;
		logic [7:0] status;
		logic       rx_irq;
		logic       tx_irq;
		r_next   = r_reg;
		rx_irq   = 1'b0;
		tx_irq   = 1'b0;
		sel_now  = r_reg.s2.cs0 && r_reg.s2.cs1 && !r_reg.s2.cs2_n;
		en_fall  = r_reg.en_q && !r_reg.s2.en;
		per      = sas_period(ser.div);
		cts_hi   = r_reg.s2.cts_n;
		full_vis = r_reg.full && !r_reg.s2.dcd_n;
		status   = {!r_reg.irq_n, r_reg.pe, r_reg.ovr, r_reg.fe,
			cts_hi, r_reg.dcd_flag, r_reg.tx_empty_flag && !cts_hi,
			full_vis};

		// Two-stage synchroniser and edge history
		r_next.s1     = pins;
		r_next.s2     = r_reg.s1;
		r_next.en_q   = r_reg.s2.en;
		r_next.baud_q = r_reg.s2.baud;
		r_next.dcd_q  = r_reg.s2.dcd_n;

		// Baud edge and bit tick divider
		r_next.edge_p = r_reg.s2.baud && !r_reg.baud_q;
		r_next.tick_p = 1'b0;
		if (r_next.edge_p) begin
			if (r_reg.div_cnt >= per - 7'h1) begin
				r_next.div_cnt = 7'h0;
				r_next.tick_p  = 1'b1;
			end else begin
				r_next.div_cnt = r_reg.div_cnt + 7'h1;
			end
		end

		// Capture the access while enable is high
		if (r_reg.s2.en) begin
			r_next.acc_sel = sel_now;
			r_next.acc_rs  = r_reg.s2.rs;
			r_next.acc_rw  = r_reg.s2.rw;
			r_next.acc_d   = r_reg.s2.d;
		end

		// Drive read data during enable only
		r_next.oe_n = 1'b1;
		if (r_reg.s2.en && sel_now && r_reg.s2.rw) begin
			r_next.oe_n = 1'b0;
			if (r_reg.s2.rs == `SAS_RS_DATA) begin
				r_next.dout = r_reg.rx_data_reg;
			end else begin
				r_next.dout = status;
			end
		end

		// Hand the data register to the transmitter
		r_next.go = 1'b0;
		if (!r_reg.tx_empty_flag && !ser.tx_busy && !r_reg.go && !ser.mr) begin
			r_next.go   = 1'b1;
			r_next.tx_empty_flag = 1'b1;
		end

		// Access takes effect at the end of enable
		if (en_fall && r_reg.acc_sel) begin
			if (!r_reg.acc_rw) begin
				if (r_reg.acc_rs == `SAS_RS_CTRL) begin
					r_next.ctrl = r_reg.acc_d;
				end else begin
					r_next.tdr  = r_reg.acc_d;
					r_next.tx_empty_flag = 1'b0;
				end
			end else if (r_reg.acc_rs == `SAS_RS_CTRL) begin
				r_next.stat_rd = r_reg.dcd_flag;
			end else begin
				if (r_reg.ovr) begin
					r_next.ovr  = 1'b0;
					r_next.full = 1'b0;
				end else if (r_reg.ovr_pend) begin
					r_next.ovr      = 1'b1;
					r_next.ovr_pend = 1'b0;
				end else begin
					r_next.full = 1'b0;
				end
				if (r_reg.stat_rd) begin
					r_next.dcd_flag = r_reg.s2.dcd_n;
					r_next.stat_rd  = 1'b0;
				end
			end
		end

		// Carrier loss latches, winning over a clear
		if (r_reg.s2.dcd_n && !r_reg.dcd_q) begin
			r_next.dcd_flag = 1'b1;
		end

		// Received character lands or overruns
		if (ser.rx_done) begin
			if (!r_next.full) begin
				r_next.rx_data_reg  = ser.rx_data;
				r_next.full = 1'b1;
				r_next.fe   = ser.rx_fe;
				r_next.pe   = ser.rx_pe;
			end else if (!r_next.ovr) begin
				r_next.ovr_pend = 1'b1;
			end
		end

		// Master reset clears flags, sets transmit-empty, loads carrier-loss from its pin, keeps clear-to-send
		if (ser.mr) begin
			r_next.full     = 1'b0;
			r_next.fe       = 1'b0;
			r_next.pe       = 1'b0;
			r_next.ovr      = 1'b0;
			r_next.ovr_pend = 1'b0;
			r_next.dcd_flag = r_reg.s2.dcd_n;
			r_next.stat_rd  = 1'b0;
			r_next.tx_empty_flag     = 1'b1;
			r_next.go       = 1'b0;
		end

		// Interrupt request from enabled conditions
		rx_irq = r_reg.ctrl[`SAS_RIE_BIT] && (full_vis || r_reg.ovr ||
			r_reg.dcd_flag);
		tx_irq = (r_reg.ctrl[`SAS_TXC_MSB:`SAS_TXC_LSB] == `SAS_TXC_INT) &&
			r_reg.tx_empty_flag && !cts_hi;
		r_next.irq_n = !(rx_irq || tx_irq);

		// Serial output with break override
		if (r_reg.ctrl[`SAS_TXC_MSB:`SAS_TXC_LSB] == `SAS_TXC_BRK) begin
			r_next.txd = 1'b0;
		end else begin
			r_next.txd = ser.tx_txd;
		end

		if (!rst_b_i) begin
			r_next = TOP_RST;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		r_reg <= r_next;
	end

	// ****************************************************
	// Outputs
	// ****************************************************

	assign data_o      = r_reg.dout;
	assign data_oe_n_o = r_reg.oe_n;
	assign irq_n_o     = r_reg.irq_n;
	assign txd_o       = r_reg.txd;
	assign rts_n_o     = r_reg.ctrl[`SAS_RTS_BIT];

endmodule

// File: verilog/sas_tx.sv
/*
 * Transmit shifter: start, data LSB first, parity, stop bits.
 * Assumes one tick_p pulse per bit time and go only while idle.
 */
module sas_tx
	import sas_pkg::*;
(
	input  wire logic clk_i,
	input  wire logic rst_b_i,
	sas_ser_if.tx_mp  ser
);

	typedef struct packed {
		sas_ser_st_t st;
		logic        pend;
		logic [7:0]  shift;
		logic [2:0]  idx;
		logic        par;
		logic        stop2;
		logic        txd;
	} tx_state_t;

	localparam tx_state_t TX_RST = '{st: SER_IDLE, txd: 1'b1, default: '0};

	tx_state_t r_reg;
	tx_state_t r_next;
	sas_fmt_t  fmt;

	assign fmt         = sas_fmt_decode(ser.fmt);
	assign ser.tx_busy = r_reg.pend || (r_reg.st != SER_IDLE);
	assign ser.tx_txd  = r_reg.txd;

	// Bit sequencer, advances once per bit tick
	always_comb begin
		r_next = r_reg;
		if (ser.go && !ser.tx_busy) begin
			r_next.pend  = 1'b1;
			r_next.shift = ser.tdr;
		end
		if (ser.tick_p) begin
			case (r_reg.st)
				SER_IDLE: begin
					if (r_reg.pend) begin
						r_next.pend = 1'b0;
						r_next.st   = SER_START;
						r_next.txd  = 1'b0;
						r_next.idx  = 3'h0;
						r_next.par  = fmt.odd;
					end
				end
				SER_START, SER_DATA: begin
					if (r_reg.st == SER_DATA &&
						r_reg.idx == (fmt.eight ? 3'h7 : 3'h6)) begin
						r_next.st    = fmt.par_en ? SER_PAR : SER_STOP;
						r_next.txd   = fmt.par_en ? r_reg.par : 1'b1;
						r_next.stop2 = fmt.two_stop;
					end else begin
						if (r_reg.st == SER_DATA) begin
							r_next.idx = r_reg.idx + 3'h1;
						end
						r_next.st    = SER_DATA;
						r_next.txd   = r_reg.shift[0];
						r_next.par   = r_reg.par ^ r_reg.shift[0];
						r_next.shift = {1'b0, r_reg.shift[7:1]};
					end
				end
				SER_PAR: begin
					r_next.st  = SER_STOP;
					r_next.txd = 1'b1;
				end
				SER_STOP: begin
					if (r_reg.stop2) begin
						r_next.stop2 = 1'b0;
					end else begin
						r_next.st = SER_IDLE;
					end
				end
				default: begin
					r_next = TX_RST;
				end
			endcase
		end
		if (!rst_b_i || ser.mr) begin
			r_next = TX_RST;
		end
	end

	// State register
	always_ff @(posedge clk_i) begin
		r_reg <= r_next;
	end

endmodule
